// file: src/card_fsm_cfg.svh
`ifndef CARD_FSM_CFG_SVH
`define CARD_FSM_CFG_SVH
// Answer byte after a level 1 select while another level follows
`define SAK_CASCADE_MORE  8'h04
// Answer byte once anticollision is complete
`define SAK_COMPLETE      8'h00
// Page address that triggers the shortcut select
`define SHORTCUT_PAGE     8'h00
`endif

// file: src/card_fsm_pkg.sv
`default_nettype none
package card_fsm_pkg;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_READY1 = 3'b001,
      ST_READY2 = 3'b010,
      ST_ACTIVE = 3'b011,
      ST_TRACE  = 3'b100,
      ST_AUTH   = 3'b101,
      ST_HALT   = 3'b110
   } card_state_t;

   // Decoded command kinds from the framing layer
   typedef enum logic [3:0] {
      CMD_REQA     = 4'h0,
      CMD_WUPA     = 4'h1,
      CMD_ANTICOL1 = 4'h2,
      CMD_SELECT1  = 4'h3,
      CMD_ANTICOL2 = 4'h4,
      CMD_SELECT2  = 4'h5,
      CMD_READ     = 4'h6,
      CMD_HLTA     = 4'h7,
      CMD_AUTH_OK  = 4'h8,
      CMD_VIRTUAL_CARD_SELECT_CMD_CMD = 4'h9,
      CMD_MEM      = 4'ha,
      CMD_UID_SIG  = 4'hb,
      CMD_SECURE   = 4'hc,
      CMD_OTHER    = 4'hf
   } card_cmd_t;

   typedef enum logic [1:0] {
      KEY_DATA_PROT = 2'h0,
      KEY_ID_RETR   = 2'h1,
      KEY_GENUINE   = 2'h2
   } auth_key_t;

   // One received command, presented for one cycle
   typedef struct packed {
      card_cmd_t  cmd;
      logic [7:0] page;
      auth_key_t  key;
      logic       page_protected;
      logic       counter2_access;
   } card_req_t;

   // Verdict for one command
   typedef struct packed {
      logic       accept;
      logic       reject;
      logic       sak_valid;
      logic [7:0] sak;
   } card_rsp_t;
endpackage
`default_nettype wire

// file: src/contactless_card_state_machine.sv
// Function
// - Power-on reset enters idle, idle is waiting state.
// - Idle leaves only on request or wake-up; other data stays idle.
// - Halt command in active, traceable, authenticated enters halt; halt becomes waiting.
// - Halt answers only wake-up; reader must use wake-up to reactivate.
// - Unexpected command returns to waiting state, idle or halt.
// - Ready1 handles level 1 anticollision and select.
// - Double-size identifier: level 1 select answers 04h, go ready2.
// - Random identifier: level 1 select goes active, answer complete.
// - Read page 00h in ready1 or ready2 goes straight active.
// - Other data in ready1 falls back to waiting state.
// - Ready2 handles level 2 anticollision.
// - Level 2 select answers complete and enters active.
// - Other data in ready2 falls back to waiting state.
// - Active allows memory operations, rejects those needing authentication.
// - Active: halt to halt; auth to authenticated or traceable by key.
// - Traceable: halt to halt; auth to authenticated or active by key.
// - Authenticated: halt to halt; auth to traceable or active by key.
// - Virtual card select accepted only in active.
// - Traceable acts as active; random identifier adds identifier and signature reads.
// - Secure messaging supported in traceable.
// - Authenticated adds protected pages and protected counter two.
// - Unsupported data in active states returns to waiting state.
`timescale 1ns/1ps
`default_nettype none
`include "card_fsm_cfg.svh"

module contactless_card_state_machine (
   input  wire logic                    sys_clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    req_valid_i,
   input  wire card_fsm_pkg::card_req_t req_i,
   input  wire logic                    random_id_i,
   input  wire logic                    counter2_prot_i,
   output logic                         rsp_valid_o,
   output card_fsm_pkg::card_rsp_t      rsp_o,
   output card_fsm_pkg::card_state_t    state_o,
   output logic                         halted_o
);

   card_fsm_pkg::card_state_t state_q;
   card_fsm_pkg::card_state_t state_d;
   card_fsm_pkg::card_state_t wait_st;
   card_fsm_pkg::card_rsp_t   rsp_d;
   logic                      halted_q;
   logic                      halted_d;
   logic                      rsp_valid_q;
   card_fsm_pkg::card_rsp_t   rsp_q;
   logic                      need_auth;

   // Where errors fall back to, chosen by history
   assign wait_st   = halted_q ? card_fsm_pkg::ST_HALT : card_fsm_pkg::ST_IDLE;
   // Protected counter counts as a protected page
   assign need_auth = req_i.page_protected | (req_i.counter2_access & counter2_prot_i);

   // Next state and verdict for one command
   always_comb begin
      state_d  = state_q;
      halted_d = halted_q;
      rsp_d    = '0;
      if (req_valid_i) begin
         rsp_d.accept = 1'b1;
         case (state_q)
            card_fsm_pkg::ST_IDLE: begin
               if (req_i.cmd == card_fsm_pkg::CMD_REQA ||
                   req_i.cmd == card_fsm_pkg::CMD_WUPA) begin
                  state_d = card_fsm_pkg::ST_READY1;
               end else begin
                  rsp_d.accept = 1'b0;
               end
            end
            card_fsm_pkg::ST_HALT: begin
               if (req_i.cmd == card_fsm_pkg::CMD_WUPA) begin
                  state_d = card_fsm_pkg::ST_READY1;
               end else begin
                  rsp_d.accept = 1'b0;
               end
            end
            card_fsm_pkg::ST_READY1: begin
               if (req_i.cmd == card_fsm_pkg::CMD_ANTICOL1) begin
                  state_d = card_fsm_pkg::ST_READY1;
               end else if (req_i.cmd == card_fsm_pkg::CMD_SELECT1) begin
                  rsp_d.sak_valid = 1'b1;
                  if (random_id_i) begin
                     rsp_d.sak = `SAK_COMPLETE;
                     state_d   = card_fsm_pkg::ST_ACTIVE;
                  end else begin
                     rsp_d.sak = `SAK_CASCADE_MORE;
                     state_d   = card_fsm_pkg::ST_READY2;
                  end
               end else if (req_i.cmd == card_fsm_pkg::CMD_READ &&
                            req_i.page == `SHORTCUT_PAGE) begin
                  state_d = card_fsm_pkg::ST_ACTIVE;
               end else begin
                  rsp_d.accept = 1'b0;
                  state_d      = wait_st;
               end
            end
            card_fsm_pkg::ST_READY2: begin
               if (req_i.cmd == card_fsm_pkg::CMD_ANTICOL2) begin
                  state_d = card_fsm_pkg::ST_READY2;
               end else if (req_i.cmd == card_fsm_pkg::CMD_SELECT2) begin
                  rsp_d.sak_valid = 1'b1;
                  rsp_d.sak       = `SAK_COMPLETE;
                  state_d         = card_fsm_pkg::ST_ACTIVE;
               end else if (req_i.cmd == card_fsm_pkg::CMD_READ &&
                            req_i.page == `SHORTCUT_PAGE) begin
                  state_d = card_fsm_pkg::ST_ACTIVE;
               end else begin
                  rsp_d.accept = 1'b0;
                  state_d      = wait_st;
               end
            end
            card_fsm_pkg::ST_ACTIVE,
            card_fsm_pkg::ST_TRACE,
            card_fsm_pkg::ST_AUTH: begin
               case (req_i.cmd)
                  card_fsm_pkg::CMD_HLTA: begin
                     state_d  = card_fsm_pkg::ST_HALT;
                     halted_d = 1'b1;
                  end
                  card_fsm_pkg::CMD_AUTH_OK: begin
                     case (req_i.key)
                        card_fsm_pkg::KEY_DATA_PROT: begin
                           if (state_q == card_fsm_pkg::ST_AUTH) begin
                              rsp_d.accept = 1'b0;
                              state_d      = wait_st;
                           end else begin
                              state_d = card_fsm_pkg::ST_AUTH;
                           end
                        end
                        card_fsm_pkg::KEY_ID_RETR: begin
                           if (state_q == card_fsm_pkg::ST_TRACE) begin
                              rsp_d.accept = 1'b0;
                              state_d      = wait_st;
                           end else begin
                              state_d = card_fsm_pkg::ST_TRACE;
                           end
                        end
                        card_fsm_pkg::KEY_GENUINE: begin
                           if (state_q == card_fsm_pkg::ST_ACTIVE) begin
                              rsp_d.accept = 1'b0;
                              state_d      = wait_st;
                           end else begin
                              state_d = card_fsm_pkg::ST_ACTIVE;
                           end
                        end
                        default: begin
                           rsp_d.accept = 1'b0;
                           state_d      = wait_st;
                        end
                     endcase
                  end
                  card_fsm_pkg::CMD_VIRTUAL_CARD_SELECT_CMD_CMD: begin
                     if (state_q != card_fsm_pkg::ST_ACTIVE) begin
                        rsp_d.accept = 1'b0;
                        rsp_d.reject = 1'b1;
                     end
                  end
                  card_fsm_pkg::CMD_MEM,
                  card_fsm_pkg::CMD_READ: begin
                     if (need_auth && state_q != card_fsm_pkg::ST_AUTH) begin
                        rsp_d.accept = 1'b0;
                        rsp_d.reject = 1'b1;
                     end
                  end
                  card_fsm_pkg::CMD_UID_SIG: begin
                     // With random id, privacy reads are refused in active
                     if (state_q == card_fsm_pkg::ST_ACTIVE && random_id_i) begin
                        rsp_d.accept = 1'b0;
                        rsp_d.reject = 1'b1;
                     end
                  end
                  card_fsm_pkg::CMD_SECURE: begin
                     if (state_q == card_fsm_pkg::ST_ACTIVE) begin
                        rsp_d.accept = 1'b0;
                        rsp_d.reject = 1'b1;
                     end
                  end
                  default: begin
                     rsp_d.accept = 1'b0;
                     state_d      = wait_st;
                  end
               endcase
            end
            default: begin
               rsp_d.accept = 1'b0;
               state_d      = wait_st;
            end
         endcase
      end
   end

   // Protocol state; power-on always starts idle
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_q <= card_fsm_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Halt history; only a reset forgets it, so errors keep landing in halt
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         // Idle is the waiting state after reset
         halted_q <= 1'b0;
      end else begin
         halted_q <= halted_d;
      end
   end

   // Registered verdict, one cycle per command
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rsp_valid_q <= 1'b0;
         rsp_q       <= '0;
      end else begin
         rsp_valid_q <= req_valid_i;
         rsp_q       <= rsp_d;
      end
   end

   assign rsp_valid_o = rsp_valid_q;
   assign rsp_o       = rsp_q;
   assign state_o     = state_q;
   assign halted_o    = halted_q;

endmodule
`default_nettype wire

// file: bench/card_fsm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module card_fsm_properties (
   input wire logic                      sys_clk_i,
   input wire logic                      rst_i,
   input wire logic                      req_valid_i,
   input wire card_fsm_pkg::card_req_t   req_i,
   input wire logic                      random_id_i,
   input wire logic                      counter2_prot_i,
   input wire logic                      rsp_valid_o,
   input wire card_fsm_pkg::card_rsp_t   rsp_o,
   input wire card_fsm_pkg::card_state_t state_o,
   input wire logic                      halted_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Command kind taken this edge and state groups
   card_fsm_pkg::card_cmd_t c;
   logic                    rdy;
   logic                    run;
   assign c = req_i.cmd;
   assign rdy = req_valid_i && state_o inside {card_fsm_pkg::ST_READY1, card_fsm_pkg::ST_READY2};
   assign run = req_valid_i && state_o inside {card_fsm_pkg::ST_ACTIVE, card_fsm_pkg::ST_TRACE,
      card_fsm_pkg::ST_AUTH};
   a_answer_next: assert property (req_valid_i |=> rsp_valid_o)
      else $error("no answer one cycle after a command");
   a_answer_cause: assert property (rsp_valid_o |-> $past(req_valid_i))
      else $error("answer without a command");
   a_idle_holds: assert property (req_valid_i && state_o == card_fsm_pkg::ST_IDLE &&
      !(c inside {card_fsm_pkg::CMD_REQA, card_fsm_pkg::CMD_WUPA})
      |=> state_o == card_fsm_pkg::ST_IDLE) else $error("idle left on a wrong command");
   a_halt_wakeup: assert property (req_valid_i && state_o == card_fsm_pkg::ST_HALT &&
      c != card_fsm_pkg::CMD_WUPA |=> state_o == card_fsm_pkg::ST_HALT)
      else $error("halt left without wake-up");
   a_sel1_double: assert property (rdy && c == card_fsm_pkg::CMD_SELECT1 && !random_id_i
      && state_o == card_fsm_pkg::ST_READY1 |=> state_o == card_fsm_pkg::ST_READY2
      && rsp_o.sak_valid && rsp_o.sak == 8'h04) else $error("level one select wrong");
   a_sel1_random: assert property (rdy && c == card_fsm_pkg::CMD_SELECT1 && random_id_i
      && state_o == card_fsm_pkg::ST_READY1 |=> state_o == card_fsm_pkg::ST_ACTIVE
      && rsp_o.sak_valid && rsp_o.sak == 8'h00) else $error("random id select wrong");
   a_read0_direct: assert property (rdy && c == card_fsm_pkg::CMD_READ && req_i.page == 8'h00
      |=> state_o == card_fsm_pkg::ST_ACTIVE) else $error("page zero read not active");
   a_ready_error: assert property (rdy && c == card_fsm_pkg::CMD_OTHER |=> state_o ==
      ($past(halted_o) ? card_fsm_pkg::ST_HALT : card_fsm_pkg::ST_IDLE))
      else $error("ready error not back to waiting state");
   a_hlta_halts: assert property (run && c == card_fsm_pkg::CMD_HLTA
      |=> state_o == card_fsm_pkg::ST_HALT && halted_o) else $error("halt command ignored");
   a_virtual_card_select_cmd_refused: assert property (run && c == card_fsm_pkg::CMD_VIRTUAL_CARD_SELECT_CMD_CMD &&
      state_o != card_fsm_pkg::ST_ACTIVE |=> rsp_o.reject && !rsp_o.accept)
      else $error("virtual select taken outside active");
endmodule
bind contactless_card_state_machine card_fsm_properties chk_u (.sys_clk_i, .rst_i,
   .req_valid_i, .req_i, .random_id_i, .counter2_prot_i, .rsp_valid_o, .rsp_o, .state_o,
   .halted_o);
`default_nettype wire

// file: bench/reader_model.sv
`timescale 1ns/1ps
`default_nettype none
module reader_model (
   input  wire logic               sys_clk_i,
   output logic                    req_valid_o,
   output card_fsm_pkg::card_req_t req_o
);
   initial begin
      req_valid_o = 1'b0;
      req_o = '0;
   end
   // Called after a falling edge; holds one command over one rising edge
   task automatic send(input card_fsm_pkg::card_req_t r);
      req_valid_o = 1'b1;
      req_o = r;
      @(negedge sys_clk_i);
   endtask
   // Released lines scrambled so a stale command never looks valid
   task automatic quiet();
      req_valid_o = 1'b0;
      req_o = ~req_o;
   endtask
endmodule
`default_nettype wire

// file: bench/contactless_card_state_machine_tb.sv
`timescale 1ns/1ps
`default_nettype none
module contactless_card_state_machine_tb;
   logic                      sys_clk, rst, random_identifier, c2p, req_valid, rsp_valid, halted, pp, c2;
   card_fsm_pkg::card_req_t   req;
   card_fsm_pkg::card_rsp_t   rsp;
   card_fsm_pkg::card_state_t state;
   card_fsm_pkg::auth_key_t   key;
   logic [7:0]                pg;
   int                        miscompares, checked, cyc;
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   contactless_card_state_machine dut_u (.sys_clk_i(sys_clk), .rst_i(rst),
      .req_valid_i(req_valid), .req_i(req), .random_id_i(random_identifier), .counter2_prot_i(c2p),
      .rsp_valid_o(rsp_valid), .rsp_o(rsp), .state_o(state), .halted_o(halted));
   reader_model rdr_u (.sys_clk_i(sys_clk), .req_valid_o(req_valid), .req_o(req));
   task automatic test_done();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // One command; ar is {accept, reject}, 0 means error fall-back
   task automatic op(input card_fsm_pkg::card_cmd_t c, input logic [2:0] es,
      input logic [1:0] ar);
      rdr_u.send('{c, pg, key, pp, c2});
      chk("answer", {2'h0, rsp_valid, es, rsp.accept, rsp.reject}, {2'h0, 1'b1, es, ar});
      chk("state", {5'h0, state}, {5'h0, es});
   endtask
   task automatic sak_is(input logic [7:0] e);
      chk("sak_valid", {7'h0, rsp.sak_valid}, 8'h01);
      chk("sak", rsp.sak, e);
   endtask
   task automatic t_reset();
      chk("reset", {4'h0, state, halted}, {4'h0, card_fsm_pkg::ST_IDLE, 1'b0});
      $display("t_reset done");
   endtask
   // Full double-size cascade, back to back, ending in halt
   task automatic t_cascade();
      op(card_fsm_pkg::CMD_READ, card_fsm_pkg::ST_IDLE, 2'h0);
      op(card_fsm_pkg::CMD_REQA, card_fsm_pkg::ST_READY1, 2'h2);
      op(card_fsm_pkg::CMD_ANTICOL1, card_fsm_pkg::ST_READY1, 2'h2);
      op(card_fsm_pkg::CMD_SELECT1, card_fsm_pkg::ST_READY2, 2'h2);
      sak_is(8'h04);
      op(card_fsm_pkg::CMD_ANTICOL2, card_fsm_pkg::ST_READY2, 2'h2);
      op(card_fsm_pkg::CMD_SELECT2, card_fsm_pkg::ST_ACTIVE, 2'h2);
      sak_is(8'h00);
      op(card_fsm_pkg::CMD_VIRTUAL_CARD_SELECT_CMD_CMD, card_fsm_pkg::ST_ACTIVE, 2'h2);
      pp = 1'b1;
      op(card_fsm_pkg::CMD_MEM, card_fsm_pkg::ST_ACTIVE, 2'h1);
      pp = 1'b0;
      op(card_fsm_pkg::CMD_HLTA, card_fsm_pkg::ST_HALT, 2'h2);
      chk("halted", {7'h0, halted}, 8'h01);
      $display("t_cascade done");
   endtask
   // Halted history: errors fall back to halt, wake-up needed
   task automatic t_halt();
      op(card_fsm_pkg::CMD_REQA, card_fsm_pkg::ST_HALT, 2'h0);
      op(card_fsm_pkg::CMD_WUPA, card_fsm_pkg::ST_READY1, 2'h2);
      op(card_fsm_pkg::CMD_OTHER, card_fsm_pkg::ST_HALT, 2'h0);
      op(card_fsm_pkg::CMD_WUPA, card_fsm_pkg::ST_READY1, 2'h2);
      op(card_fsm_pkg::CMD_SELECT1, card_fsm_pkg::ST_READY2, 2'h2);
      op(card_fsm_pkg::CMD_OTHER, card_fsm_pkg::ST_HALT, 2'h0);
      random_identifier = 1'b1;
      op(card_fsm_pkg::CMD_WUPA, card_fsm_pkg::ST_READY1, 2'h2);
      op(card_fsm_pkg::CMD_SELECT1, card_fsm_pkg::ST_ACTIVE, 2'h2);
      sak_is(8'h00);
      op(card_fsm_pkg::CMD_OTHER, card_fsm_pkg::ST_HALT, 2'h0);
      $display("t_halt done");
   endtask
   // Shortcut read from ready2, then every key transition
   task automatic t_keys();
      random_identifier = 1'b0;
      op(card_fsm_pkg::CMD_WUPA, card_fsm_pkg::ST_READY1, 2'h2);
      op(card_fsm_pkg::CMD_SELECT1, card_fsm_pkg::ST_READY2, 2'h2);
      op(card_fsm_pkg::CMD_READ, card_fsm_pkg::ST_ACTIVE, 2'h2);
      random_identifier = 1'b1;
      key = card_fsm_pkg::KEY_ID_RETR;
      op(card_fsm_pkg::CMD_AUTH_OK, card_fsm_pkg::ST_TRACE, 2'h2);
      op(card_fsm_pkg::CMD_VIRTUAL_CARD_SELECT_CMD_CMD, card_fsm_pkg::ST_TRACE, 2'h1);
      op(card_fsm_pkg::CMD_SECURE, card_fsm_pkg::ST_TRACE, 2'h2);
      op(card_fsm_pkg::CMD_UID_SIG, card_fsm_pkg::ST_TRACE, 2'h2);
      key = card_fsm_pkg::KEY_DATA_PROT;
      op(card_fsm_pkg::CMD_AUTH_OK, card_fsm_pkg::ST_AUTH, 2'h2);
      pp = 1'b1;
      op(card_fsm_pkg::CMD_MEM, card_fsm_pkg::ST_AUTH, 2'h2);
      {pp, c2, c2p} = 3'h3;
      op(card_fsm_pkg::CMD_MEM, card_fsm_pkg::ST_AUTH, 2'h2);
      op(card_fsm_pkg::CMD_VIRTUAL_CARD_SELECT_CMD_CMD, card_fsm_pkg::ST_AUTH, 2'h1);
      key = card_fsm_pkg::KEY_GENUINE;
      op(card_fsm_pkg::CMD_AUTH_OK, card_fsm_pkg::ST_ACTIVE, 2'h2);
      op(card_fsm_pkg::CMD_MEM, card_fsm_pkg::ST_ACTIVE, 2'h1);
      op(card_fsm_pkg::CMD_UID_SIG, card_fsm_pkg::ST_ACTIVE, 2'h1);
      key = card_fsm_pkg::KEY_DATA_PROT;
      op(card_fsm_pkg::CMD_AUTH_OK, card_fsm_pkg::ST_AUTH, 2'h2);
      key = card_fsm_pkg::KEY_ID_RETR;
      op(card_fsm_pkg::CMD_AUTH_OK, card_fsm_pkg::ST_TRACE, 2'h2);
      key = card_fsm_pkg::KEY_GENUINE;
      op(card_fsm_pkg::CMD_AUTH_OK, card_fsm_pkg::ST_ACTIVE, 2'h2);
      op(card_fsm_pkg::CMD_HLTA, card_fsm_pkg::ST_HALT, 2'h2);
      $display("t_keys done");
   endtask
   // Reset in mid-run clears the halted history
   task automatic t_rerun();
      rdr_u.quiet();
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      chk("halted", {7'h0, halted}, 8'h00);
      op(card_fsm_pkg::CMD_REQA, card_fsm_pkg::ST_READY1, 2'h2);
      op(card_fsm_pkg::CMD_ANTICOL2, card_fsm_pkg::ST_IDLE, 2'h0);
      rdr_u.quiet();
      $display("t_rerun done");
   endtask
   // Hang guard, far above the fifty or so cycles the tests need
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      {rst, random_identifier, c2p, pp, c2, pg} = {5'h10, 8'h00};
      key = card_fsm_pkg::KEY_DATA_PROT;
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      t_reset();
      t_cascade();
      t_halt();
      t_keys();
      t_rerun();
      test_done();
   end
endmodule
`default_nettype wire
